// File: rtl/thermal_alarm_logic.sv
/*
 Digital alarm logic of a temperature sensor: conversion pacing, threshold
 compare, fault filter, open-drain warning pin, standby, chip enable and
 undervoltage flag, with the registers on an APB slave.
 Assumes the converter presents its result on adc_temp and adc_raw in the
 core clock domain while conv_active is high; chip enable and supply
 comparators are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
module thermal_alarm_logic #(
   parameter int RECORD_CYCLES = thermal_alarm_pkg::RECORD_CYC,
   parameter int CONV_CYCLES   = thermal_alarm_pkg::CONV_CYC
) (
   input  wire logic                               core_clk,
   input  wire logic                               reset_n,
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [thermal_alarm_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                        pwdata,
   output logic      [31:0]                        prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   input  wire logic                               chip_enable,
   input  wire logic                               supply_below_hi,
   input  wire logic                               supply_below_lo,
   input  wire logic [thermal_alarm_pkg::TEMP_W-1:0] adc_temp,
   input  wire logic [thermal_alarm_pkg::RAW_W-1:0]  adc_raw,
   output logic                                    conv_active,
   output logic                                    warn_out,
   output logic                                    warn_oe
);
   import thermal_alarm_pkg::*;

   localparam int PW = $clog2(RECORD_CYCLES + 1);
   localparam int CW = $clog2(CONV_CYCLES + 1);
   localparam logic [PW-1:0] PERIOD_LAST = PW'(RECORD_CYCLES - 1);
   localparam logic [CW-1:0] CONV_LAST   = CW'(CONV_CYCLES - 1);

   typedef struct packed {
      logic [1:0]        ce_sync;
      logic [1:0]        uvh_sync;
      logic [1:0]        uvl_sync;
      logic [CTL_W-1:0]  ctl;
      logic [TEMP_W-1:0] upper;
      logic [TEMP_W-1:0] lower;
      logic [TEMP_W-1:0] temp;
      logic [RAW_W-1:0]  raw;
      logic              updated;
      logic              high;
      logic              low;
      logic              record;
      conv_state_t       cv;
      logic [PW-1:0]     period_cnt;
      logic [CW-1:0]     conv_cnt;
      logic              int_pend;
      logic              pin_low;
   } state_t;

   state_t      s;
   state_t      next_s;
   logic        ce_on;
   logic        uv_flag;
   logic        access;
   logic        unmapped;
   logic        rd;
   logic        wr;
   logic [1:0]  idx;
   logic        alarm;
   logic        flip;
   logic        filt_clear;
   logic [15:0] status_word;

   // Signed, inclusive compare of two readings in the temperature format.
   function automatic logic at_or_above(input logic [TEMP_W-1:0] a,
                                        input logic [TEMP_W-1:0] b);
      at_or_above = $signed(a) >= $signed(b);
   endfunction : at_or_above

   ////////////////////////////////////////////////////////////////////
   // Bus decode. The slave never waits, so every access ends in its
   // first access cycle; only the low sixteen bytes are mapped.
   assign idx      = paddr[3:2];
   assign unmapped = paddr[ADDR_W-1:4] != '0 || paddr[1:0] != 2'h0;
   assign access   = psel && penable;
   assign rd       = access && !pwrite && !unmapped;
   assign wr       = access && pwrite && !unmapped;
   assign pready   = 1'b1;
   assign pslverr  = access && unmapped;

   // Synchronised pin levels; stage zero feeds only stage one.
   assign ce_on   = s.ce_sync[1];
   assign uv_flag = s.ctl[CTL_UVSEL] ? s.uvl_sync[1] : s.uvh_sync[1];

   // Status word shows the last finished conversion, never a partial one.
   always_comb begin
      if (s.ctl[CTL_RAWSEL]) begin
         status_word = {s.updated, 3'h0, s.raw};
      end else begin
         status_word = {s.updated, uv_flag, alarm, s.high, s.low, s.temp};
      end
   end

   // Read data is a mux of flip-flops; bits above sixteen read as zero.
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd) begin
         case (idx)
            IDX_STATUS:  prdata = {16'h0000, status_word};
            IDX_CONTROL: prdata = {24'h00_0000, s.ctl};
            IDX_UPPER:   prdata = {21'h00_0000, s.upper};
            IDX_LOWER:   prdata = {21'h00_0000, s.lower};
            default:     prdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // The filter is held clear while the chip is off or software asks for
   // the alarm to be cleared.
   assign filt_clear = !ce_on || s.ctl[CTL_CLRALM];

   alarm_filter u_filter (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .clear     (filt_clear),
      .record    (s.record),
      .over      (s.high),
      .under     (s.low),
      .fault_sel (s.ctl[CTL_FCNT +: 2]),
      .alarm     (alarm),
      .flip      (flip)
   );

   ////////////////////////////////////////////////////////////////////
   // Next state of the whole block.
   always_comb begin
      next_s = s;
      next_s.ce_sync  = {s.ce_sync[0], chip_enable};
      next_s.uvh_sync = {s.uvh_sync[0], supply_below_hi};
      next_s.uvl_sync = {s.uvl_sync[0], supply_below_lo};
      next_s.record   = 1'b0;

      if (!ce_on) begin
         // Chip off: everything sits at defaults, so the enable edge
         // finds a clean start and the pin is released.
         next_s.ctl        = CTL_RESET;
         next_s.upper      = UPPER_RESET;
         next_s.lower      = LOWER_RESET;
         next_s.temp       = '0;
         next_s.raw        = '0;
         next_s.updated    = 1'b0;
         next_s.high       = 1'b0;
         next_s.low        = 1'b0;
         next_s.cv         = CV_IDLE;
         next_s.period_cnt = '0;
         next_s.conv_cnt   = '0;
         next_s.int_pend   = 1'b0;
         next_s.pin_low    = 1'b0;
      end else begin
         // Register writes; thresholds apply from the next record on.
         if (wr) begin
            case (idx)
               IDX_CONTROL: next_s.ctl   = pwdata[CTL_W-1:0];
               IDX_UPPER:   next_s.upper = pwdata[TEMP_W-1:0];
               IDX_LOWER:   next_s.lower = pwdata[TEMP_W-1:0];
               default:     next_s.ctl   = s.ctl;
            endcase
         end

         // Conversion pacing. Standby stops the timer and the converter.
         if (s.ctl[CTL_STANDBY]) begin
            next_s.cv         = CV_IDLE;
            next_s.period_cnt = '0;
            next_s.conv_cnt   = '0;
         end else begin
            if (s.period_cnt == PERIOD_LAST) begin
               next_s.period_cnt = '0;
            end else begin
               next_s.period_cnt = s.period_cnt + 1'b1;
            end
            case (s.cv)
               CV_IDLE: begin
                  if (s.period_cnt == PERIOD_LAST) begin
                     next_s.cv       = CV_RUN;
                     next_s.conv_cnt = '0;
                  end
               end
               CV_RUN: begin
                  if (rd) begin
                     next_s.cv = CV_RESTART;
                  end else if (s.conv_cnt == CONV_LAST) begin
                     next_s.cv     = CV_IDLE;
                     next_s.temp   = adc_temp;
                     next_s.raw    = adc_raw;
                     next_s.record = 1'b1;
                     next_s.high   = at_or_above(adc_temp, s.upper);
                     next_s.low    = at_or_above(s.lower, adc_temp);
                  end else begin
                     next_s.conv_cnt = s.conv_cnt + 1'b1;
                  end
               end
               CV_RESTART: begin
                  // The read has ended; start a fresh conversion.
                  next_s.cv       = CV_RUN;
                  next_s.conv_cnt = '0;
               end
               default: next_s.cv = CV_IDLE;
            endcase
         end

         // Update flag: a new record wins over a read of the status word.
         if (next_s.record) begin
            next_s.updated = 1'b1;
         end else if (rd && idx == IDX_STATUS) begin
            next_s.updated = 1'b0;
         end

         // Forced clear of the compare flags while software holds it.
         if (s.ctl[CTL_CLRALM]) begin
            next_s.high = 1'b0;
            next_s.low  = 1'b0;
         end

         // Pending interrupt: any register read clears it, but a filter
         // flip in the same cycle still wins. Each flip is one interrupt:
         // first the over-limit, then the under-limit one.
         if (!s.ctl[CTL_INTMODE] || s.ctl[CTL_CLRALM]) begin
            next_s.int_pend = 1'b0;
         end else if (s.ctl[CTL_STANDBY]) begin
            next_s.int_pend = 1'b0;
         end else if (flip) begin
            next_s.int_pend = 1'b1;
         end else if (rd) begin
            next_s.int_pend = 1'b0;
         end

         // Pin level. The host keeps polarity normal in interrupt mode,
         // but an inverted setting is still honoured here.
         if (s.ctl[CTL_INTMODE]) begin
            next_s.pin_low = s.int_pend ^ ~s.ctl[CTL_INV] ^ 1'b1;
         end else if (s.ctl[CTL_CLRALM]) begin
            next_s.pin_low = 1'b0;
         end else begin
            // Standby keeps the filter still, so the level holds.
            next_s.pin_low = alarm ^ s.ctl[CTL_INV];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register. Reset loads constants only.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s       <= '0;
         s.ctl   <= CTL_RESET;
         s.upper <= UPPER_RESET;
         s.lower <= LOWER_RESET;
         s.cv    <= CV_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // Open drain: the pin is only ever pulled low or released.
   assign warn_out    = 1'b0;
   assign warn_oe     = s.pin_low;
   assign conv_active = s.cv == CV_RUN;

   ////////////////////////////////////////////////////////////////////
   // Checks on the block's own behaviour.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_read_aborts_conv: assert property (
      ce_on && s.cv == CV_RUN && rd && !s.ctl[CTL_STANDBY]
      |=> s.cv == CV_RESTART)
      else $error("Read did not abort the running conversion.");
   a_restart_follows: assert property (
      ce_on && s.cv == CV_RESTART && !s.ctl[CTL_STANDBY]
      |=> s.cv == CV_RUN && s.conv_cnt == '0)
      else $error("Aborted conversion was not restarted.");
   a_record_from_conv: assert property (
      s.record |-> $past(s.cv) == CV_RUN && s.cv == CV_IDLE && s.updated)
      else $error("Record without a finished conversion.");
   a_read_clears_int: assert property (
      ce_on && rd && !flip |=> !s.int_pend)
      else $error("Register read left the interrupt pending.");
   a_standby_int_clear: assert property (
      ce_on && s.ctl[CTL_STANDBY] && s.ctl[CTL_INTMODE] |=> !s.int_pend)
      else $error("Standby kept an interrupt pending.");
   a_int_pin_level: assert property (
      ce_on && s.ctl[CTL_INTMODE] && $past(ce_on)
      |=> warn_oe == ($past(s.int_pend) ^ $past(s.ctl[CTL_INV])))
      else $error("Interrupt mode pin level is wrong.");
   a_cmp_pin_level: assert property (
      ce_on && !s.ctl[CTL_INTMODE] && !s.ctl[CTL_CLRALM]
      |=> warn_oe == ($past(alarm) ^ $past(s.ctl[CTL_INV])))
      else $error("Comparator mode pin level is wrong.");
   a_off_defaults: assert property (
      !ce_on |=> s.ctl == CTL_RESET && !warn_oe && s.upper == UPPER_RESET)
      else $error("Chip off did not restore defaults.");

   // Pacing, capture, compare and standby checks.
   a_period_start: assert property (
      ce_on && !s.ctl[CTL_STANDBY] && s.cv == CV_IDLE && s.period_cnt == PERIOD_LAST
      |=> conv_active)
      else $error("No conversion at period end.");
   a_abort_no_record: assert property (
      ce_on && s.cv == CV_RUN && rd && !s.ctl[CTL_STANDBY]
      |=> !s.record)
      else $error("Aborted conversion made a record.");
   a_temp_held: assert property (
      ce_on && s.cv != CV_RUN
      |=> $stable(s.temp))
      else $error("Reading moved outside a conversion end.");
   a_limit_compare: assert property (
      s.record && !$past(s.ctl[CTL_CLRALM])
      |-> s.high == at_or_above(s.temp, $past(s.upper))
          && s.low == at_or_above($past(s.lower), s.temp))
      else $error("Threshold flags do not match the reading.");
   a_flip_sets_int: assert property (
      ce_on && s.ctl[CTL_INTMODE] && !s.ctl[CTL_CLRALM] && !s.ctl[CTL_STANDBY] && flip
      |=> s.int_pend)
      else $error("Flip did not raise the interrupt.");
   a_cmp_no_int: assert property (
      ce_on && !s.ctl[CTL_INTMODE]
      |=> !s.int_pend)
      else $error("Comparator mode holds an interrupt.");
   a_standby_no_conv: assert property (
      ce_on && s.ctl[CTL_STANDBY]
      |=> !conv_active)
      else $error("Conversion ran in standby.");
   a_standby_holds_alarm: assert property (
      ce_on && s.ctl[CTL_STANDBY] && !s.ctl[CTL_CLRALM] && !s.record
      |=> $stable(alarm))
      else $error("Alarm state moved in standby.");
   a_off_no_conv: assert property (
      !ce_on
      |=> !conv_active && !s.record)
      else $error("Conversion ran while off.");
endmodule : thermal_alarm_logic

// File: rtl/thermal_alarm_pkg.sv
/*
 Constants shared by the thermal alarm block: timing, register indices,
 control bit positions, reset values and the converter states.
 Assumes a single 25 MHz core clock.
*/
// Operation
// - New measurement record every quarter second.
// - Reads return last completed conversion.
// - Read aborts conversion; restart after read.
// - Qualifying records count; pin changes at limit.
// - Non-qualifying record clears the counter.
// - Fault select needs 1, 2, 4, 8.
// - Comparator, normal: low above, released below.
// - Comparator, inverted: low below, released above.
// - Interrupt mode: idle released, low when active.
// - Interrupt raised on filtered over-limit.
// - Any register read clears pending interrupt.
// - Next interrupt only below lower threshold.
// - Standby in interrupt mode clears interrupt.
// - Standby in comparator mode holds pin.
// - Control bit 0 enters standby.
// - Chip enable low off; high restores defaults.
// - Undervoltage flag by selected threshold.
// - New thresholds used by later comparisons.
// - Warning pin is open drain only.
// - Control bit 1 selects interrupt mode.
// - Control bit 2 inverts pin polarity.
// - Control register resets to zero.
// - Threshold comparisons are inclusive.
package thermal_alarm_pkg;
   localparam int CLK_HZ    = 25_000_000;
   localparam int RECORD_MS = 250;
   localparam int CONV_MS   = 105;
   localparam int RECORD_CYC = CLK_HZ / 1000 * RECORD_MS;
   localparam int CONV_CYC   = CLK_HZ / 1000 * CONV_MS;

   // Register indices; the byte address is four times the index.
   localparam logic [1:0] IDX_STATUS  = 2'h0;
   localparam logic [1:0] IDX_CONTROL = 2'h1;
   localparam logic [1:0] IDX_UPPER   = 2'h2;
   localparam logic [1:0] IDX_LOWER   = 2'h3;
   localparam int ADDR_W = 8;
   localparam int TEMP_W = 11;
   localparam int RAW_W  = 12;
   localparam int CTL_W  = 8;

   // Control register fields.
   localparam int CTL_STANDBY = 0;
   localparam int CTL_INTMODE = 1;
   localparam int CTL_INV     = 2;
   localparam int CTL_FCNT    = 3;
   localparam int CTL_RAWSEL  = 5;
   localparam int CTL_CLRALM  = 6;
   localparam int CTL_UVSEL   = 7;
   localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;

   // Threshold reset values, arbitrary neutral defaults.
   localparam logic [TEMP_W-1:0] UPPER_RESET = 11'h0F0;
   localparam logic [TEMP_W-1:0] LOWER_RESET = 11'h0E0;

   typedef enum logic [1:0] {
      CV_IDLE    = 2'b00,
      CV_RUN     = 2'b01,
      CV_RESTART = 2'b10
   } conv_state_t;
endpackage : thermal_alarm_pkg

// File: rtl/alarm_filter.sv
/*
 Consecutive-fault filter and hysteresis state of the warning output.
 Assumes one record pulse per completed conversion with its comparisons.
*/
`timescale 1ns/1ps
module alarm_filter (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       clear,
   input  wire logic       record,
   input  wire logic       over,
   input  wire logic       under,
   input  wire logic [1:0] fault_sel,
   output logic            alarm,
   output logic            flip
);
   import thermal_alarm_pkg::*;

   typedef struct packed {
      logic [3:0] count;
      logic       alarm;
      logic       flip;
   } filt_t;

   filt_t s;
   filt_t next_s;
   logic  qual;

   // Consecutive records needed for each select code.
   function automatic logic [3:0] need_count(input logic [1:0] sel);
      need_count = 4'h1 << sel;
   endfunction : need_count

   ////////////////////////////////////////////////////////////////////
   // A record qualifies when it would move the state; the comparator
   // state only moves at the far threshold, which gives hysteresis.
   always_comb begin
      next_s = s;
      next_s.flip = 1'b0;
      qual = s.alarm ? under : over;
      if (clear) begin
         next_s = '0;
      end else if (record) begin
         if (!qual) begin
            next_s.count = 4'h0;
         end else if (s.count + 4'h1 == need_count(fault_sel)) begin
            next_s.count = 4'h0;
            next_s.alarm = ~s.alarm;
            next_s.flip  = 1'b1;
         end else begin
            next_s.count = s.count + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign alarm = s.alarm;
   assign flip  = s.flip;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_flip_toggles_state: assert property (
      flip |-> alarm != $past(alarm))
      else $error("Flip pulse without a state change.");
   a_nonqual_clears_count: assert property (
      record && !qual && !clear |=> s.count == 4'h0 && !flip)
      else $error("Non-qualifying record kept the count.");
   a_single_fault_flips: assert property (
      record && qual && !clear && fault_sel == 2'h0 |=> flip)
      else $error("Single fault select did not flip at once.");
endmodule : alarm_filter

// File: tb/sensor_front_model.sv
/*
 Behavioural analog front end standing behind the alarm logic.
 Assumes the core samples the result only while conv_active is high.
*/
`timescale 1ns/1ps
module sensor_front_model (
   input  wire logic                                 conv_active,
   input  wire logic [thermal_alarm_pkg::TEMP_W-1:0] temp_set,
   output logic      [thermal_alarm_pkg::TEMP_W-1:0] adc_temp,
   output logic      [thermal_alarm_pkg::RAW_W-1:0]  adc_raw
);
   import thermal_alarm_pkg::*;
   // Outside a conversion the lines carry the inverse, so a late sample shows up.
   assign adc_temp = conv_active ? temp_set : ~temp_set;
   assign adc_raw  = {adc_temp, 1'b1};
endmodule : sensor_front_model

// File: tb/testbench.sv
/*
 Self-checking bench for the thermal alarm logic over APB.
 Assumes zero-wait APB and shortened record and conversion counts.
*/
`timescale 1ns/1ps
module testbench;
   import thermal_alarm_pkg::*;
   localparam int          RC   = 200;
   localparam int          CC   = 40;
   localparam logic [7:0]  A_ST = 8'h00;
   localparam logic [7:0]  A_CT = 8'h04;
   localparam logic [7:0]  A_UP = 8'h08;
   localparam logic [7:0]  A_LO = 8'h0C;
   localparam logic [10:0] OV   = 11'h100;
   localparam logic [10:0] UN   = 11'h0D0;
   logic              core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic              chip_enable, sup_hi, sup_lo, conv_active, warn_out, warn_oe;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              er;
   logic [TEMP_W-1:0] temp_set, adc_temp;
   logic [RAW_W-1:0]  adc_raw;
   int                n_errors = 0;
   int                n_tests = 0;
   int                k;
   time               t0;

   thermal_alarm_logic #(.RECORD_CYCLES(RC), .CONV_CYCLES(CC)) u_dut (
      .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chip_enable(chip_enable),
      .supply_below_hi(sup_hi), .supply_below_lo(sup_lo), .adc_temp(adc_temp),
      .adc_raw(adc_raw), .conv_active(conv_active), .warn_out(warn_out),
      .warn_oe(warn_oe));

   sensor_front_model u_front (.conv_active(conv_active), .temp_set(temp_set),
      .adc_temp(adc_temp), .adc_raw(adc_raw));

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and the checking helpers.
   task automatic final_report;
      if (n_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One APB transfer; the request is held until pready is seen at an edge.
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
      xfer(a, 1'b0, 32'h0);
      check(name, rd, exp);
      check("pslverr", er, 1'b0);
   endtask : rchk

   // Bounded wait for a conversion level; a miss shows as a mismatch.
   task automatic wait_cv(input logic v, input int lim, input string name);
      int n;
      n = 0;
      while (conv_active !== v && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      check(name, conv_active, v);
   endtask : wait_cv

   // Lets cnt whole records complete, then the pipeline down to the pin settle.
   task automatic rec(input int cnt);
      repeat (cnt) begin
         wait_cv(1'b1, RC + 10, "conv_start");
         wait_cv(1'b0, CC + 10, "conv_end");
      end
      repeat (6) @(posedge core_clk);
   endtask : rec

   task automatic idle_chk(input int cyc);
      k = 0;
      repeat (cyc) begin
         @(posedge core_clk);
         if (conv_active !== 1'b0) k++;
      end
      check("standby_conv", k, 0);
   endtask : idle_chk

   ////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog; the watchdog spans several times the planned run.
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      n_errors++;
      final_report;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      chip_enable = 1'b1;
      sup_hi = 1'b0;
      sup_lo = 1'b0;
      temp_set = 11'h0C8;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      check("warn_oe_reset", warn_oe, 1'b0);
      rchk(A_CT, 32'h0, "control_reset");
      rchk(A_UP, UPPER_RESET, "upper_reset");
      rchk(A_LO, LOWER_RESET, "lower_reset");
      xfer(8'h10, 1'b0, 32'h0);
      check("unmapped_err", er, 1'b1);
      xfer(8'h06, 1'b1, 32'hFF);
      check("misaligned_err", er, 1'b1);
      wr(A_LO, 32'hFFFFFFFF);
      rchk(A_LO, 32'h7FF, "lower_width");
      wr(A_LO, LOWER_RESET);
      // Record pacing and the last completed value.
      wait_cv(1'b1, RC + 10, "conv_start");
      t0 = $time;
      wait_cv(1'b0, CC + 10, "conv_end");
      wait_cv(1'b1, RC + 10, "conv_start");
      check("record_period", 32'(($time - t0) / 40), RC);
      wait_cv(1'b0, CC + 10, "conv_end");
      repeat (6) @(posedge core_clk);
      rchk(A_ST, 32'h88C8, "status_new");
      rchk(A_ST, 32'h08C8, "status_again");
      sup_hi <= 1'b1;
      repeat (4) @(posedge core_clk);
      rchk(A_ST, 32'h48C8, "undervolt_hi");
      wr(A_CT, 32'h80);
      rchk(A_ST, 32'h08C8, "undervolt_sel");
      sup_lo <= 1'b1;
      repeat (4) @(posedge core_clk);
      rchk(A_ST, 32'h48C8, "undervolt_lo");
      sup_hi <= 1'b0;
      sup_lo <= 1'b0;
      wr(A_CT, 32'h20);
      rchk(A_ST, 32'h0191, "status_raw");
      wr(A_CT, 32'h0);
      // Comparator mode, inclusive limits, hysteresis and polarity.
      wr(A_UP, 32'h0F8);
      rchk(A_UP, 32'h0F8, "upper_rw");
      temp_set <= 11'h0F8;
      rec(1);
      check("cmp_over", warn_oe, 1'b1);
      temp_set <= 11'h0E8;
      rec(1);
      check("cmp_hold", warn_oe, 1'b1);
      temp_set <= 11'h0E0;
      rec(1);
      check("cmp_under", warn_oe, 1'b0);
      wr(A_CT, 32'h04);
      rec(1);
      check("inv_under", warn_oe, 1'b1);
      temp_set <= OV;
      rec(1);
      check("inv_over", warn_oe, 1'b0);
      temp_set <= UN;
      rec(1);
      wr(A_CT, 32'h0);
      // Every fault count code, with a break in the run of qualifying records.
      for (int c = 0; c < 4; c++) begin
         wr(A_CT, c << 3);
         temp_set <= OV;
         rec((1 << c) - 1);
         check("fault_early", warn_oe, 1'b0);
         temp_set <= UN;
         rec(1);
         temp_set <= OV;
         rec((1 << c) - 1);
         check("fault_restart", warn_oe, 1'b0);
         rec(1);
         check("fault_trip", warn_oe, 1'b1);
         temp_set <= UN;
         rec(1 << c);
         check("fault_back", warn_oe, 1'b0);
      end
      // Interrupt mode; polarity stays normal here.
      wr(A_CT, 32'h02);
      temp_set <= OV;
      rec(1);
      check("int_over", warn_oe, 1'b1);
      rec(1);
      check("int_pending", warn_oe, 1'b1);
      xfer(A_ST, 1'b0, 32'h0);
      repeat (3) @(posedge core_clk);
      check("int_cleared", warn_oe, 1'b0);
      temp_set <= UN;
      rec(1);
      check("int_under", warn_oe, 1'b1);
      xfer(A_UP, 1'b0, 32'h0);
      repeat (3) @(posedge core_clk);
      check("int_cleared2", warn_oe, 1'b0);
      temp_set <= OV;
      rec(1);
      wr(A_CT, 32'h03);
      repeat (3) @(posedge core_clk);
      check("int_standby", warn_oe, 1'b0);
      idle_chk(500);
      // Standby in comparator mode keeps the pin where it was.
      wr(A_CT, 32'h0);
      wr(A_CT, 32'h01);
      temp_set <= UN;
      idle_chk(500);
      check("cmp_standby", warn_oe, 1'b1);
      wr(A_CT, 32'h40);
      repeat (3) @(posedge core_clk);
      check("clear_alarm", warn_oe, 1'b0);
      // A read during a conversion aborts it and restarts a fresh one.
      wr(A_CT, 32'h0);
      wait_cv(1'b1, RC + 10, "conv_start");
      repeat (5) @(posedge core_clk);
      xfer(A_ST, 1'b0, 32'h0);
      wait_cv(1'b0, 3, "conv_abort");
      wait_cv(1'b1, 3, "conv_restart");
      // Chip enable cycle restores defaults.
      wr(A_UP, 32'h123);
      wr(A_CT, 32'h06);
      chip_enable <= 1'b0;
      repeat (4) @(posedge core_clk);
      chip_enable <= 1'b1;
      repeat (4) @(posedge core_clk);
      check("ce_pin", warn_oe, 1'b0);
      rchk(A_CT, 32'h0, "ce_control");
      rchk(A_UP, UPPER_RESET, "ce_upper");
      check("open_drain", warn_out, 1'b0);
      final_report;
   end
endmodule : testbench
